/* design/pem_port_e_regs.vh */
// Register offsets, field positions and reset values for the port E pin block
`ifndef PEM_PORT_E_REGS_VH
`define PEM_PORT_E_REGS_VH

// Register offsets (byte addresses on the plain register port)
`define PEM_OFF_PIN_VALUE    4'h0
`define PEM_OFF_OUT_LATCH    4'h1
`define PEM_OFF_DIRECTION    4'h2
`define PEM_OFF_PAD_CFG      4'h3
`define PEM_OFF_OD_CTRL_A    4'h4
`define PEM_OFF_OD_CTRL_B    4'h5
`define PEM_OFF_FUNC_CTRL    4'h6
`define PEM_OFF_STATUS       4'h7

// Field positions
`define PEM_PAD_PULLUP_DIS   6
`define PEM_ODA_UNIT2_OD     6
`define PEM_FN_EXT_BUS       0
`define PEM_FN_SLV_PORT      1
`define PEM_FN_REFCLK        2
`define PEM_FN_PWM_REMAP     3
`define PEM_FN_UNIT2_SEL     4
`define PEM_FN_MCU_MODE      5
`define PEM_FN_PKG80         6

// Reset values
`define PEM_RST_LATCH        8'h00
`define PEM_RST_DIRECTION    8'hFF
`define PEM_RST_PAD_CFG      8'h40
`define PEM_RST_OD           8'h00
`define PEM_RST_FUNC         8'h38

// Reference clock divider: half period in system clock cycles
`define PEM_REFCLK_HALF      8'h02

`endif

/* design/pem_pin_cell.v */
// One port E pin: output selection, drive enable, pull-up and open-drain
`timescale 1ns/1ps
module pem_pin_cell (
   input  wire       mclk,          // System clock
   input  wire       rst,           // Synchronous reset, active high
   input  wire       dirIn,         // Direction bit, 1 = input
   input  wire       latchBit,      // Output latch bit
   input  wire       pullupDis,     // Shared pull-up disable
   input  wire       busOwn,        // Memory bus owns the pin
   input  wire       busOut,        // Memory bus data out
   input  wire       busOe,         // Memory bus drives
   input  wire       slvOwn,        // Slave port owns the pin (strobe input)
   input  wire       refOwn,        // Reference clock owns the pin
   input  wire       refClk,        // Reference clock level
   input  wire       perOwn,        // Capture/compare or PWM owns the pin
   input  wire       perOut,        // Compare/PWM output level
   input  wire       perTri,        // PWM shutdown forces high impedance
   input  wire       openDrain,     // Open-drain drive for peripheral output
   output reg        padOut_r,      // Pad output level
   output reg        padOe_r,       // Pad output enable
   output reg        padPu_r        // Pad weak pull-up enable
);

   reg outNxt;    // Next pad level
   reg oeNxt;     // Next pad enable

   // Fixed-priority owner choice: bus, slave port, ref clock, peripheral, latch
   always @* begin
      outNxt = latchBit;
      oeNxt  = ~dirIn;
      if (busOwn) begin
         outNxt = busOut;
         oeNxt  = busOe;
      end else if (slvOwn) begin
         outNxt = 1'b0;
         oeNxt  = 1'b0;
      end else if (refOwn) begin
         outNxt = refClk;
         oeNxt  = 1'b1;
      end else if (perOwn) begin
         outNxt = perOut;
         oeNxt  = ~dirIn & ~perTri;
         // Open drain: drive low only, release high
         if (openDrain) begin
            oeNxt  = oeNxt & ~perOut;
            outNxt = 1'b0;
         end
      end
   end

   // Registered pad controls; reset leaves the pin an input with no pull-up
   always @(posedge mclk) begin
      if (rst) begin
         padOut_r <= 1'b0;
         padOe_r  <= 1'b0;
         padPu_r  <= 1'b0;
      end else begin
         padOut_r <= outNxt;
         padOe_r  <= oeNxt;
         padPu_r  <= ~pullupDis & ~oeNxt;
      end
   end

endmodule

/* design/pem_port_e.v */
// Port E eight-pin GPIO with alternate function multiplexing and register port
// Functional notes
// - Eight pins; direction 0 drives latch, 1 inputs
// - Any reset makes all pins inputs
// - Shared pad bit 6 disables all pull-ups
// - Driven pins never get a pull-up
// - Pull-ups disabled after any reset
// - Open-drain bit 6 makes unit-two pin7 open-drain
// - Default PWM B/C/D outputs on pins 6..0
// - 80-pin remap clear moves unit1/3 B,C away
// - Unit-two select clear puts unit two on pin7 in MCU mode
// - Slave port: pin0 read, pin1 write, pin2 select
// - Reference clock drives pin3 regardless of direction
// - Peripheral output overrides latch; input feeds capture
// - PWM outputs tri-state on shutdown when configured
// - Memory bus carries address/data 8..15 both ways
// - Bus, slave port, refclock override direction bit
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "pem_port_e_regs.vh"
module pem_port_e (
   input  wire       mclk,             // System clock, 250 MHz
   input  wire       rst,              // Synchronous reset, active high
   input  wire [3:0] regAddr,          // Register address
   input  wire [7:0] regWrData,        // Register write data
   input  wire       regWrStb,         // Write strobe
   input  wire       regRdStb,         // Read strobe
   output reg  [7:0] regRdData_r,      // Read data, valid the cycle after a read
   input  wire [7:0] padIn,            // Pin levels seen at the pads
   output wire [7:0] padOut,           // Pin output levels (from flip-flops)
   output wire [7:0] padOe,            // Pin output enables (from flip-flops)
   output wire [7:0] padPullup,        // Weak pull-up enables (from flip-flops)
   input  wire [7:0] extBusOut,        // Memory bus data 15..8 out
   input  wire       extBusOe,         // Memory bus drives the data byte
   output reg  [7:0] extBusIn_r,       // Memory bus data 15..8 in
   output reg  [2:0] slvStrobes_r,     // Slave port read, write, select inputs
   input  wire       unit1PwmOutB,     // Unit one PWM output B
   input  wire       unit1PwmOutC,     // Unit one PWM output C
   input  wire       unit2PwmOutA,     // Unit two compare/PWM output A
   input  wire       unit2PwmOutB,     // Unit two PWM output B
   input  wire       unit2PwmOutC,     // Unit two PWM output C
   input  wire       unit2PwmOutD,     // Unit two PWM output D
   input  wire       unit3PwmOutB,     // Unit three PWM output B
   input  wire       unit3PwmOutC,     // Unit three PWM output C
   input  wire [7:0] pwmActive,        // Per-pin PWM or compare output enabled
   input  wire [7:0] pwmShutTri,       // Per-pin shutdown tri-state request
   output reg        unit2CaptureIn_r  // Pin 7 level to unit two capture
);

   // Configuration and data registers
   reg  [7:0] outLatch_r;     // Output latch
   reg  [7:0] direction_r;    // Direction, 1 = input
   reg  [7:0] padCfg_r;       // Pad configuration
   reg  [7:0] odCtrlA_r;      // Open-drain control A
   reg  [7:0] odCtrlB_r;      // Open-drain control B (held for software only)
   reg  [7:0] funcCtrl_r;     // Alternate function enables and config bits
   reg  [7:0] pinSample_r;    // Sampled pin levels
   reg  [7:0] refCnt_r;       // Reference clock divider counter
   reg        refClk_r;       // Reference clock level
   reg  [7:0] rdNxt;          // Read data next value

   wire [7:0] pinOut;         // Cell outputs
   wire [7:0] pinOe;          // Cell enables
   wire [7:0] pinPu;          // Cell pull-ups
   wire [7:0] perOut;         // Peripheral output per pin
   wire [7:0] perOwn;         // Peripheral owns pin
   wire       busEn;          // Memory bus active
   wire       slvEn;          // Slave port active
   wire       refEn;          // Reference clock enabled
   wire       remapKeep;      // Unit one/three B,C stay on this port
   wire       unit2Here;      // Unit two function lives on pin 7

   // Address decode for the write path; the read mux decodes with its own case
   function hit;
      input [3:0] addr;
      input [3:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   assign busEn     = funcCtrl_r[`PEM_FN_EXT_BUS] & funcCtrl_r[`PEM_FN_PKG80];
   assign slvEn     = funcCtrl_r[`PEM_FN_SLV_PORT] & funcCtrl_r[`PEM_FN_MCU_MODE];
   assign refEn     = funcCtrl_r[`PEM_FN_REFCLK];
   // Remap only exists on the larger package; small parts always keep them
   assign remapKeep = funcCtrl_r[`PEM_FN_PWM_REMAP] | ~funcCtrl_r[`PEM_FN_PKG80];
   assign unit2Here = ~funcCtrl_r[`PEM_FN_UNIT2_SEL] & funcCtrl_r[`PEM_FN_MCU_MODE];

   // Peripheral outputs per pin: default placement on pins 6..0, unit two on 7
   assign perOut = {unit2PwmOutA, unit1PwmOutB, unit1PwmOutC, unit3PwmOutB,
                    unit3PwmOutC, unit2PwmOutB, unit2PwmOutC, unit2PwmOutD};
   assign perOwn = pwmActive & {unit2Here, remapKeep, remapKeep, remapKeep,
                                remapKeep, 3'b111};

   // Pin cells, one per bit
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : gCell
         pem_pin_cell uCell (
            .mclk      (mclk),
            .rst       (rst),
            .dirIn     (direction_r[gi]),
            .latchBit  (outLatch_r[gi]),
            .pullupDis (padCfg_r[`PEM_PAD_PULLUP_DIS]),
            .busOwn    (busEn),
            .busOut    (extBusOut[gi]),
            .busOe     (extBusOe),
            .slvOwn    (slvEn && (gi < 3)),
            .refOwn    (refEn && (gi == 3)),
            .refClk    (refClk_r),
            .perOwn    (perOwn[gi]),
            .perOut    (perOut[gi]),
            .perTri    (pwmShutTri[gi]),
            .openDrain ((gi == 7) && odCtrlA_r[`PEM_ODA_UNIT2_OD]),
            .padOut_r  (pinOut[gi]),
            .padOe_r   (pinOe[gi]),
            .padPu_r   (pinPu[gi])
         );
      end
   endgenerate

   assign padOut    = pinOut;
   assign padOe     = pinOe;
   assign padPullup = pinPu;

   // Reference clock: divide the system clock, free-running while enabled
   always @(posedge mclk) begin
      if (rst || !refEn) begin
         refCnt_r <= 8'h00;
         refClk_r <= 1'b0;
      end else if (refCnt_r == `PEM_REFCLK_HALF - 8'h01) begin
         refCnt_r <= 8'h00;
         refClk_r <= ~refClk_r;
      end else begin
         refCnt_r <= refCnt_r + 8'h01;
      end
   end

   // Input path: sample pins, feed bus, slave port and capture inputs
   always @(posedge mclk) begin
      if (rst) begin
         pinSample_r      <= 8'h00;
         extBusIn_r       <= 8'h00;
         slvStrobes_r     <= 3'b000;
         unit2CaptureIn_r <= 1'b0;
      end else begin
         pinSample_r      <= padIn;
         extBusIn_r       <= busEn ? padIn : 8'h00;
         // Strobes are held inactive unless the slave port owns the pins
         slvStrobes_r     <= (slvEn && !busEn) ? padIn[2:0] : 3'b000;
         unit2CaptureIn_r <= unit2Here & direction_r[7] & padIn[7];
      end
   end

   // Register writes; writing the pin value register loads the latch
   always @(posedge mclk) begin
      if (rst) begin
         outLatch_r  <= `PEM_RST_LATCH;
         direction_r <= `PEM_RST_DIRECTION;
         padCfg_r    <= `PEM_RST_PAD_CFG;
         odCtrlA_r   <= `PEM_RST_OD;
         odCtrlB_r   <= `PEM_RST_OD;
         funcCtrl_r  <= `PEM_RST_FUNC;
      end else if (regWrStb) begin
         if (hit(regAddr, `PEM_OFF_PIN_VALUE) || hit(regAddr, `PEM_OFF_OUT_LATCH))
            outLatch_r <= regWrData;
         if (hit(regAddr, `PEM_OFF_DIRECTION))
            direction_r <= regWrData;
         if (hit(regAddr, `PEM_OFF_PAD_CFG))
            padCfg_r <= regWrData;
         if (hit(regAddr, `PEM_OFF_OD_CTRL_A))
            odCtrlA_r <= regWrData;
         if (hit(regAddr, `PEM_OFF_OD_CTRL_B))
            odCtrlB_r <= regWrData;
         if (hit(regAddr, `PEM_OFF_FUNC_CTRL))
            funcCtrl_r <= regWrData;
      end
   end

   // Read mux; the direction register reads back software's value, not overrides
   always @* begin
      case (regAddr)
         `PEM_OFF_PIN_VALUE: rdNxt = pinSample_r;
         `PEM_OFF_OUT_LATCH: rdNxt = outLatch_r;
         `PEM_OFF_DIRECTION: rdNxt = direction_r;
         `PEM_OFF_PAD_CFG:   rdNxt = padCfg_r;
         `PEM_OFF_OD_CTRL_A: rdNxt = odCtrlA_r;
         `PEM_OFF_OD_CTRL_B: rdNxt = odCtrlB_r;
         `PEM_OFF_FUNC_CTRL: rdNxt = funcCtrl_r;
         `PEM_OFF_STATUS:    rdNxt = pinOe;
         default:            rdNxt = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rst)
         regRdData_r <= 8'h00;
      else if (regRdStb)
         regRdData_r <= rdNxt;
      else
         regRdData_r <= 8'h00;
   end

endmodule

/* tb/pem_port_e_assertions.sv */
// Port-level checker for the port E pin block
`timescale 1ns/1ps
module pem_port_e_assertions (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrStb,
   input wire logic       regRdStb,
   input wire logic [7:0] regRdData_r,
   input wire logic [7:0] padIn,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullup,
   input wire logic [7:0] extBusIn_r,
   input wire logic [2:0] slvStrobes_r,
   input wire logic       unit2CaptureIn_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Pins come out of reset as undriven inputs
   AST_RST_INPUTS: assert property ($fell(rst) |-> padOe == 8'h00)
      else $error("pins driven right after reset");
   AST_RST_PULLUP: assert property ($fell(rst) |-> padPullup == 8'h00)
      else $error("pull-ups on right after reset");
   // A driven pin never carries a pull-up as well
   AST_PU_DRIVEN: assert property ((padOe & padPullup) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_PU_DISABLE: assert property (regWrStb && regAddr == 4'h3 && regWrData[6] |-> ##2 padPullup == 8'h00)
      else $error("shared pull-up disable ignored");
   // Read data stands one cycle only, unmapped places read zero
   AST_RD_IDLE: assert property (!regRdStb |=> regRdData_r == 8'h00)
      else $error("read data without a read");
   AST_UNMAPPED: assert property (regRdStb && regAddr[3] |=> regRdData_r == 8'h00)
      else $error("unmapped read not zero");
   // Alternate inputs follow the pad one cycle late
   AST_SLV_SAMPLE: assert property (slvStrobes_r != 3'h0 |-> slvStrobes_r == $past(padIn[2:0]))
      else $error("slave port strobes not from pins 2..0");
   AST_BUS_SAMPLE: assert property (extBusIn_r != 8'h00 |-> extBusIn_r == $past(padIn))
      else $error("memory bus input not from pins");
   AST_CAPTURE: assert property (unit2CaptureIn_r |-> $past(padIn[7]))
      else $error("capture input not from pin 7");
endmodule
bind pem_port_e pem_port_e_assertions u_chk (.mclk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb,
   .regRdData_r, .padIn, .padOe, .padPullup, .extBusIn_r, .slvStrobes_r, .unit2CaptureIn_r);

/* tb/pem_board_model.sv */
// Board circuitry on the eight port E pins
`timescale 1ns/1ps
module pem_board_model (
   input  wire logic       mclk,
   input  wire logic [7:0] padOut,
   input  wire logic [7:0] padOe,
   input  wire logic [7:0] padPullup,
   input  wire logic [7:0] boardEn,
   input  wire logic [7:0] boardVal,
   output logic      [7:0] padIn
);
   logic [7:0] flick = 8'h55; // Floating pins wander so no stale level passes
   always @(posedge mclk) begin
      flick <= ~flick;
   end
   // Device drive wins, then board drive, then weak pull-up, else floating
   always_comb begin
      padIn = (padOe & padOut) | (~padOe & boardEn & boardVal) | (~padOe & ~boardEn & padPullup)
            | (~padOe & ~boardEn & ~padPullup & flick);
   end
endmodule

/* tb/test_pem_port_e.sv */
// Self-checking bench for the port E pin block
`timescale 1ns/1ps
`include "pem_port_e_regs.vh"
module test_pem_port_e;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWrStb = 1'b0;
   logic       regRdStb = 1'b0;
   wire  [7:0] regRdData_r, padIn, padOut, padOe, padPullup, extBusIn_r;
   wire  [2:0] slvStrobes_r;
   wire        unit2CaptureIn_r;
   logic [7:0] extBusOut = 8'h00, pwmActive = 8'h00, pwmShutTri = 8'h00, unitOut = 8'h00;
   logic       extBusOe = 1'b0;
   logic [7:0] boardEn = 8'hFF, boardVal = 8'h00, got, lat, dir;
   logic       prev;
   integer     seed = 99, error_cnt = 0, checks_done = 0, i;
   always #2 mclk = ~mclk;
   // unitOut order pin7..0: 2A,1B,1C,3B,3C,2B,2C,2D
   pem_port_e uut (.mclk, .rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData_r, .padIn, .padOut,
      .padOe, .padPullup, .extBusOut, .extBusOe, .extBusIn_r, .slvStrobes_r, .unit1PwmOutB(unitOut[6]),
      .unit1PwmOutC(unitOut[5]), .unit2PwmOutA(unitOut[7]), .unit2PwmOutB(unitOut[2]),
      .unit2PwmOutC(unitOut[1]), .unit2PwmOutD(unitOut[0]), .unit3PwmOutB(unitOut[4]),
      .unit3PwmOutC(unitOut[3]), .pwmActive, .pwmShutTri, .unit2CaptureIn_r);
   pem_board_model board (.mclk, .padOut, .padOe, .padPullup, .boardEn, .boardVal, .padIn);
   // Reset value of each register place, zero where nothing is mapped
   function automatic logic [7:0] rstVal(input integer a);
      case (a)
         2: rstVal = `PEM_RST_DIRECTION;
         3: rstVal = `PEM_RST_PAD_CFG;
         6: rstVal = `PEM_RST_FUNC;
         default: rstVal = 8'h00;
      endcase
   endfunction
   // Pin level: output pins show the latch, input pins the board
   function automatic logic [7:0] expPin(input logic [7:0] l, input logic [7:0] d, input logic [7:0] b);
      expPin = (l & ~d) | (b & d);
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One-cycle write (w=1) or read (w=0); read data lands in got
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= w;
      regRdStb <= !w;
      @(posedge mclk);
      regWrStb <= 1'b0;
      regRdStb <= 1'b0;
      #1 got = regRdData_r;
   endtask
   // Pad outputs follow a write one edge after bus returns; allow two spare
   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic give_verdict;
      $display("mismatches %0d of %0d checks", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk(padOe, 8'h00);
      chk(padPullup, 8'h00);
      bus(1'b1, 4'hC, 8'hFF);
      for (i = 1; i < 16; i++) begin
         bus(1'b0, i[3:0], 8'h00);
         chk(got, rstVal(i));
      end
      bus(1'b1, `PEM_OFF_PAD_CFG, 8'h00);
      // Random latch and direction, corners all-out and all-in first
      for (i = 0; i < 20; i++) begin
         lat = $random(seed);
         dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $random(seed);
         @(posedge mclk);
         boardVal <= $random(seed);
         bus(1'b1, i[0] ? `PEM_OFF_PIN_VALUE : `PEM_OFF_OUT_LATCH, lat);
         bus(1'b1, `PEM_OFF_DIRECTION, dir);
         settle;
         chk(padOe, ~dir);
         chk(padOut & ~dir, lat & ~dir);
         chk(padPullup, dir);
         bus(1'b0, `PEM_OFF_PIN_VALUE, 8'h00);
         chk(got, expPin(lat, dir, boardVal));
      end
      bus(1'b1, `PEM_OFF_PAD_CFG, 8'h40);
      settle;
      chk(padPullup, 8'h00);
      // PWM outputs on pins 6..0, then remap, then shutdown
      @(posedge mclk);
      unitOut <= $random(seed);
      pwmActive <= 8'h7F;
      bus(1'b1, `PEM_OFF_DIRECTION, 8'h00);
      settle;
      chk(padOut & 8'h7F, unitOut & 8'h7F);
      bus(1'b1, `PEM_OFF_OUT_LATCH, ~unitOut);
      bus(1'b1, `PEM_OFF_FUNC_CTRL, 8'h70);
      settle;
      chk(padOut & 8'h78, ~unitOut & 8'h78);
      pwmShutTri <= 8'h07;
      settle;
      chk(padOe & 8'h07, 8'h00);
      // Unit two on pin 7, open-drain
      pwmActive <= 8'h80;
      bus(1'b1, `PEM_OFF_FUNC_CTRL, 8'h60);
      bus(1'b1, `PEM_OFF_OD_CTRL_A, 8'h40);
      for (i = 0; i < 2; i++) begin
         unitOut[7] <= i[0];
         settle;
         chk(padOe & 8'h80, i[0] ? 8'h00 : 8'h80);
      end
      boardVal <= $random(seed) | 8'h80;
      bus(1'b1, `PEM_OFF_DIRECTION, 8'hFF);
      settle;
      chk({7'h00, unit2CaptureIn_r}, {7'h00, boardVal[7]});
      // A low pin must reach the capture input as low too
      @(posedge mclk);
      boardVal[7] <= 1'b0;
      settle;
      chk({7'h00, unit2CaptureIn_r}, 8'h00);
      // Reference clock on pin 3 despite input direction
      bus(1'b1, `PEM_OFF_FUNC_CTRL, 8'h24);
      settle;
      chk(padOe, 8'h08);
      got = 8'h00;
      prev = padOut[3];
      repeat (16) begin
         @(posedge mclk);
         #1 got = got + (padOut[3] !== prev);
         prev = padOut[3];
      end
      chk(got, 8'h08);
      // Slave port strobes on pins 0..2 override direction 0
      bus(1'b1, `PEM_OFF_DIRECTION, 8'h00);
      bus(1'b1, `PEM_OFF_FUNC_CTRL, 8'h22);
      settle;
      chk(padOe & 8'h07, 8'h00);
      chk({5'h00, slvStrobes_r}, {5'h00, boardVal[2:0]});
      // Memory bus beats slave port and owns all pins both ways
      extBusOut <= $random(seed);
      extBusOe <= 1'b1;
      bus(1'b1, `PEM_OFF_FUNC_CTRL, 8'h63);
      settle;
      chk(padOut, extBusOut);
      chk(padOe, 8'hFF);
      bus(1'b0, `PEM_OFF_STATUS, 8'h00);
      chk(got, 8'hFF);
      extBusOe <= 1'b0;
      settle;
      chk(padOe, 8'h00);
      chk(extBusIn_r, boardVal);
      // Plain storage places read back what was written
      for (i = 0; i < 4; i++) begin
         lat = $random(seed);
         bus(1'b1, i[0] ? `PEM_OFF_OD_CTRL_B : `PEM_OFF_OUT_LATCH, lat);
         bus(1'b0, i[0] ? `PEM_OFF_OD_CTRL_B : `PEM_OFF_OUT_LATCH, 8'h00);
         chk(got, lat);
      end
      give_verdict;
   end
endmodule
